// >>> common/flash_status_pkg.sv
// Types shared by the serial flash status block.
// Assumes the constants header is compiled alongside.
package flash_status_pkg;

    typedef enum logic [1:0] {
        FRAME_IDLE,
        FRAME_CMD,
        FRAME_READ
    } frame_state_t;

endpackage

// >>> common/flash_status_regs.svh
// Constants of the serial flash status block: opcodes, status bit positions, reset values.
// Assumes inclusion by bare name from the design files.
//
// Functional notes
// R1 - Fail flag refreshed after each program or erase; one on bad byte, zero on success.
// R2 - Aborted operations never set the fail flag.
// R3 - Guard pin level readable as a status bit.
// R4 - Software protection summary reports none, some or all sectors protected.
// R5 - Guarded commands are rejected while the write latch is clear.
// R6 - Write latch is zero after power-up and after a reset operation.
// R7 - Write latch clears when guarded operations complete or abort, or hold aborts; a write enable in the same cycle sets it instead.
// R8 - Incomplete or unknown opcode leaves the write latch untouched.
// R9 - Reset command allow is zero at power-up; reset command ignored unless set.
// R10 - Reset command allow changes only by status byte two write or power cycle.
// R11 - Lockdown allow is zero at power-up; lockdown commands ignored unless set.
// R12 - Lockdown allow is never cleared as a side effect of other operations.
// R13 - After freeze lockdown, lockdown allow is forced to zero for good.
// R14 - Program and erase halted flags report suspended sectors.
// R15 - Busy flag is one during internal program or erase; host polls it.
// R16 - Host sets the write latch with write enable before a status write.
// R17 - Status byte one write is opcode 01h plus one data byte; extra bytes ignored.
// R18 - Data bit 7 is the new lock, bits 5 to 2 the global code.
// R19 - Chip select release after a valid write updates the lock and clears the latch.
// R20 - Global protect decision uses bits 5 to 2 and the lock held before.
// R21 - Release off a byte boundary aborts: lock kept, no global action, latch cleared.
// R22 - With guard pin asserted the lock may only be set; clearing is ignored.
// R23 - Protection summary codes: 00 none, 01 some, 11 all, 10 reserved.
// R24 - Guard pin state sits at bit 4 of byte one; zero when asserted.
// R25 - Reset allow at bit 4, lockdown allow at bit 3 of byte two.
// R26 - Lock is zero at power-up and untouched by the reset command.
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

`define OP_WRITE_STATUS_LOW 8'h01
`define OP_WRITE_STATUS_HIGH 8'h31
`define OP_READ_STATUS 8'h05
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_SOFT_RESET 8'hF0
`define SOFT_RESET_CONFIRM 8'hD0

`define LOW_LOCK_BIT 7
`define LOW_FAIL_BIT 5
`define LOW_GUARD_BIT 4
`define LOW_SOFT_HI 3
`define LOW_SOFT_LO 2
`define LOW_LATCH_BIT 1
`define BUSY_BIT 0
`define HIGH_RESET_ALLOW_BIT 4
`define HIGH_LOCKDOWN_BIT 3
`define HIGH_PROG_HALT_BIT 2
`define HIGH_ERASE_HALT_BIT 1
`define CODE_HI 5
`define CODE_LO 2

`define SOFT_NONE 2'h0
`define SOFT_SOME 2'h1
`define SOFT_ALL 2'h3

`define RESET_LOCK 1'h0
`define RESET_LATCH 1'h0
`define RESET_RESET_ALLOW 1'h0
`define RESET_LOCKDOWN 1'h0
`define RESET_FAIL 1'h0

`endif

// >>> common/spi_frame_if.sv
// Byte level view of one serial frame, passed from the pin sampler to the status logic.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
`default_nettype none
interface spi_frame_if;
    logic cs_active;
    logic frame_end;
    logic sck_fall;
    logic byte_valid;
    logic [7:0] byte_data;
    logic [1:0] byte_count;
    logic bit_aligned;

    modport producer (
        output cs_active, frame_end, sck_fall, byte_valid, byte_data, byte_count, bit_aligned
    );
    modport consumer (
        input cs_active, frame_end, sck_fall, byte_valid, byte_data, byte_count, bit_aligned
    );
endinterface
`default_nettype wire

// >>> core/serial_flash_status_register.sv
// Status bytes and write-enable logic of a serial flash, with the status writes.
// Assumes an array engine on core_clk that runs program, erase and lockdown operations.
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_regs.svh"
module serial_flash_status_register (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Serial pins.
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    output logic so_pin,
    output logic so_oe,
    // Write guard pin, active low.
    input wire logic write_guard_n_pin,
    // Array engine state.
    input wire logic busy_in,
    input wire logic program_suspended,
    input wire logic erase_suspended,
    input wire logic all_sectors_protected,
    input wire logic some_sectors_protected,
    // Array engine events.
    input wire logic op_checked,
    input wire logic op_failed,
    input wire logic guarded_op_end,
    input wire logic hold_abort,
    input wire logic freeze_done,
    // Status fields.
    output logic [7:0] flash_status_low,
    output logic [7:0] flash_status_high,
    output logic write_latch,
    output logic protect_regs_lock,
    output logic reset_cmd_allow,
    output logic lockdown_allow,
    output logic program_erase_fail,
    // Requests to the array engine.
    output logic global_op_req,
    output logic [3:0] global_op_code,
    output logic global_prior_lock,
    output logic soft_reset_req
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling.

    spi_frame_if link ();

    spi_pin_sampler sampler (
        .core_clk(core_clk),
        .rst(rst),
        .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin),
        .si_pin(si_pin),
        .link(link)
    );

    logic guard_s1, guard_s2;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            guard_s1 <= 1'h1;
            guard_s2 <= 1'h1;
        end else begin
            guard_s1 <= write_guard_n_pin;
            guard_s2 <= guard_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame tracking.

    flash_status_pkg::frame_state_t state_reg, state_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [7:0] data_reg, data_next;

    wire first_byte = link.byte_valid && link.byte_count == 2'h1;
    wire second_byte = link.byte_valid && link.byte_count == 2'h2;
    wire is_read = link.byte_data == `OP_READ_STATUS;

    always_comb begin
        state_next = state_reg;
        if (link.frame_end || !link.cs_active) begin
            state_next = flash_status_pkg::FRAME_IDLE;
        end else if (first_byte) begin
            state_next = is_read ? flash_status_pkg::FRAME_READ : flash_status_pkg::FRAME_CMD;
        end
        case (state_reg)
            flash_status_pkg::FRAME_IDLE: cmd_next = first_byte ? link.byte_data : cmd_reg;
            flash_status_pkg::FRAME_CMD: cmd_next = cmd_reg;
            flash_status_pkg::FRAME_READ: cmd_next = cmd_reg;
            default: cmd_next = cmd_reg;
        endcase
    end

    // Only the first data byte is kept; later bytes fall away. (see R17)
    assign data_next = second_byte ? link.byte_data : data_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= flash_status_pkg::FRAME_IDLE;
            cmd_reg <= 8'h00;
            data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            data_reg <= data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // End of frame decode.

    function automatic logic cmd_is(input logic [7:0] cmd, input logic [7:0] op);
        cmd_is = (cmd == op);
    endfunction

    logic latch_reg, latch_next;
    logic lock_reg, lock_next;
    logic rst_allow_reg, rst_allow_next;
    logic lockdown_reg, lockdown_next;
    logic frozen_reg, frozen_next;
    logic fail_reg, fail_next;

    // A full opcode has arrived before release; shorter frames change nothing. (see R8)
    wire end_evt = link.frame_end && state_reg == flash_status_pkg::FRAME_CMD;
    wire has_data = link.byte_count >= 2'h2;
    wire write_ok = has_data && link.bit_aligned;
    wire guard_on = !guard_s2;
    wire new_lock = data_reg[`LOW_LOCK_BIT];

    wire ws_low = end_evt && cmd_is(cmd_reg, `OP_WRITE_STATUS_LOW);
    wire ws_high = end_evt && cmd_is(cmd_reg, `OP_WRITE_STATUS_HIGH);
    // Status writes need the latch set beforehand. (see R5) (see R16)
    wire ws_low_taken = ws_low && latch_reg;
    wire ws_high_taken = ws_high && latch_reg;
    // Misaligned release or a clearing attempt under the guard pin drops the write.
    wire ws_low_apply = ws_low_taken && write_ok && !(guard_on && !new_lock); // see R21 see R22
    wire ws_high_apply = ws_high_taken && write_ok; // see R21
    wire wr_enable = end_evt && cmd_is(cmd_reg, `OP_WRITE_ENABLE) && link.bit_aligned;
    wire wr_disable = end_evt && cmd_is(cmd_reg, `OP_WRITE_DISABLE) && link.bit_aligned;
    // The reset command runs only when allowed and confirmed. (see R9)
    wire reset_evt = end_evt && cmd_is(cmd_reg, `OP_SOFT_RESET) && write_ok &&
                     data_reg == `SOFT_RESET_CONFIRM && rst_allow_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Status bits.

    // Write enable sets the latch; otherwise it clears on write disable, a status write, any end of a guarded operation, a hold abort or reset. (see R7)
    wire latch_clear = wr_disable || ws_low_taken || ws_high_taken || guarded_op_end ||
                       hold_abort || reset_evt; // see R6 see R19
    assign latch_next = wr_enable ? 1'h1 : (latch_clear ? 1'h0 : latch_reg);

    // Lock follows data bit 7 only on an applied byte one write. (see R18) (see R26)
    assign lock_next = ws_low_apply ? new_lock : lock_reg; // see R19

    // Only the byte two write moves these, except that freeze clears lockdown allow; reset leaves them alone. (see R10) (see R12)
    assign rst_allow_next = ws_high_apply ? data_reg[`HIGH_RESET_ALLOW_BIT] : rst_allow_reg;
    assign frozen_next = frozen_reg || freeze_done;
    // Once frozen, lockdown allow stays zero. (see R13) (see R11)
    assign lockdown_next = frozen_next ? 1'h0 :
                           (ws_high_apply ? data_reg[`HIGH_LOCKDOWN_BIT] : lockdown_reg);

    // Only checked completions refresh the fail flag; aborts never reach it. (see R1) (see R2)
    assign fail_next = op_checked ? op_failed : fail_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_reg <= `RESET_LATCH; // see R6
            lock_reg <= `RESET_LOCK; // see R26
            rst_allow_reg <= `RESET_RESET_ALLOW; // see R9
            lockdown_reg <= `RESET_LOCKDOWN; // see R11
            frozen_reg <= 1'h0;
            fail_reg <= `RESET_FAIL;
        end else begin
            latch_reg <= latch_next;
            lock_reg <= lock_next;
            rst_allow_reg <= rst_allow_next;
            lockdown_reg <= lockdown_next;
            frozen_reg <= frozen_next;
            fail_reg <= fail_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status byte assembly.

    logic [1:0] soft_guard_state;
    logic [7:0] low_now, high_now;

    // Summary of sector protection; code 10 is never produced. (see R4) (see R23)
    assign soft_guard_state = all_sectors_protected ? `SOFT_ALL :
                              (some_sectors_protected ? `SOFT_SOME : `SOFT_NONE);

    always_comb begin
        low_now = 8'h00;
        low_now[`LOW_LOCK_BIT] = lock_reg;
        low_now[`LOW_FAIL_BIT] = fail_reg;
        low_now[`LOW_GUARD_BIT] = guard_s2; // see R3 see R24
        low_now[`LOW_SOFT_HI:`LOW_SOFT_LO] = soft_guard_state;
        low_now[`LOW_LATCH_BIT] = latch_reg;
        low_now[`BUSY_BIT] = busy_in; // see R15
        high_now = 8'h00;
        high_now[`HIGH_RESET_ALLOW_BIT] = rst_allow_reg; // see R25
        high_now[`HIGH_LOCKDOWN_BIT] = lockdown_reg; // see R25
        high_now[`HIGH_PROG_HALT_BIT] = program_suspended; // see R14
        high_now[`HIGH_ERASE_HALT_BIT] = erase_suspended; // see R14
        high_now[`BUSY_BIT] = busy_in; // see R15
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status read shifter.

    logic [2:0] out_bit_reg;
    logic [6:0] out_shift_reg;
    logic out_sel_reg;
    logic so_reg, so_oe_reg;
    wire reading = state_reg == flash_status_pkg::FRAME_READ && link.cs_active;
    wire [7:0] fresh_byte = out_sel_reg ? high_now : low_now;

    // Each byte is sampled afresh on its first falling edge so polling sees busy drop.
    always_ff @(posedge core_clk) begin
        if (rst || !reading) begin
            out_bit_reg <= 3'h0;
            out_shift_reg <= 7'h00;
            out_sel_reg <= 1'h0;
            so_reg <= 1'h0;
            so_oe_reg <= 1'h0;
        end else begin
            so_oe_reg <= 1'h1;
            if (link.sck_fall) begin
                out_bit_reg <= out_bit_reg + 3'h1;
                if (out_bit_reg == 3'h0) begin
                    so_reg <= fresh_byte[7]; // see R15
                    out_shift_reg <= fresh_byte[6:0];
                end else begin
                    so_reg <= out_shift_reg[6];
                    out_shift_reg <= {out_shift_reg[5:0], 1'h0};
                end
                if (out_bit_reg == 3'h7) begin
                    out_sel_reg <= !out_sel_reg;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flash_status_low <= 8'h00;
            flash_status_high <= 8'h00;
            global_op_req <= 1'h0;
            global_op_code <= 4'h0;
            global_prior_lock <= 1'h0;
            soft_reset_req <= 1'h0;
        end else begin
            flash_status_low <= low_now;
            flash_status_high <= high_now;
            // Global action offered with the lock held before this write. (see R20)
            global_op_req <= ws_low_apply; // see R21
            if (ws_low_apply) begin
                global_op_code <= data_reg[`CODE_HI:`CODE_LO];
                global_prior_lock <= lock_reg;
            end
            soft_reset_req <= reset_evt;
        end
    end

    assign so_pin = so_reg;
    assign so_oe = so_oe_reg;
    assign write_latch = latch_reg;
    assign protect_regs_lock = lock_reg;
    assign reset_cmd_allow = rst_allow_reg;
    assign lockdown_allow = lockdown_reg;
    assign program_erase_fail = fail_reg;
endmodule
`default_nettype wire

// >>> core/spi_pin_sampler.sv
// Samples the serial pins on core_clk and assembles bytes of a frame.
// Assumes mode 0 or 3 framing and a serial clock well below core_clk.
`timescale 1ns/1ns
`default_nettype none
module spi_pin_sampler (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Serial pins.
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    // Byte stream.
    spi_frame_if.producer link
);
    logic cs_s1, cs_s2, cs_prev;
    logic sck_s1, sck_s2, sck_prev;
    logic si_s1, si_s2;
    logic [2:0] bit_reg;
    logic [6:0] shift_reg;
    logic [1:0] count_reg;
    logic valid_reg;
    logic [7:0] data_reg;
    wire sck_rise = sck_s2 && !sck_prev && !cs_s2;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            {cs_s1, cs_s2, cs_prev} <= 3'h7;
            {sck_s1, sck_s2, sck_prev} <= 3'h0;
            {si_s1, si_s2} <= 2'h0;
        end else begin
            cs_s1 <= cs_n_pin;
            cs_s2 <= cs_s1;
            cs_prev <= cs_s2;
            sck_s1 <= sck_pin;
            sck_s2 <= sck_s1;
            sck_prev <= sck_s2;
            si_s1 <= si_pin;
            si_s2 <= si_s1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || cs_s2) begin
            bit_reg <= 3'h0;
            count_reg <= 2'h0;
            shift_reg <= 7'h00;
            valid_reg <= 1'h0;
            data_reg <= 8'h00;
        end else begin
            valid_reg <= 1'h0;
            if (sck_rise) begin
                bit_reg <= bit_reg + 3'h1;
                shift_reg <= {shift_reg[5:0], si_s2};
                if (bit_reg == 3'h7) begin
                    valid_reg <= 1'h1;
                    data_reg <= {shift_reg, si_s2};
                    if (count_reg != 2'h3) begin
                        count_reg <= count_reg + 2'h1;
                    end
                end
            end
        end
    end

    assign link.cs_active = !cs_s2;
    assign link.frame_end = cs_s2 && !cs_prev;
    assign link.sck_fall = !sck_s2 && sck_prev && !cs_s2;
    assign link.byte_valid = valid_reg;
    assign link.byte_data = data_reg;
    assign link.byte_count = count_reg;
    assign link.bit_aligned = (bit_reg == 3'h0);
endmodule
`default_nettype wire

// >>> dv/serial_flash_status_register_assertions.sv
// Checker of the serial flash status block, watching its top ports.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ns
`default_nettype none
module flash_status_checker (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Pins and engine inputs.
    input wire logic write_guard_n_pin,
    input wire logic busy_in,
    input wire logic all_sectors_protected,
    input wire logic some_sectors_protected,
    input wire logic op_checked,
    input wire logic op_failed,
    input wire logic guarded_op_end,
    input wire logic hold_abort,
    input wire logic freeze_done,
    // Status outputs.
    input wire logic [7:0] flash_status_low,
    input wire logic [7:0] flash_status_high,
    input wire logic write_latch,
    input wire logic reset_cmd_allow,
    input wire logic lockdown_allow,
    input wire logic program_erase_fail,
    input wire logic global_op_req,
    input wire logic soft_reset_req
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic frozen_reg;
    wire [1:0] soft_code = {all_sectors_protected, all_sectors_protected | some_sectors_protected};
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (rst) begin
            frozen_reg <= 1'b0;
        end else if (freeze_done) begin
            frozen_reg <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_req_one_cycle: assert property (global_op_req |=> !global_op_req)
        else $error("global request longer than one cycle");
    a_req_latch_clear: assert property (global_op_req |-> !write_latch)
        else $error("latch still set at global request");
    a_fail_follows: assert property (op_checked |=> program_erase_fail == $past(op_failed))
        else $error("fail flag does not follow the check result");
    a_fail_holds: assert property (!op_checked |=> $stable(program_erase_fail))
        else $error("fail flag changed without a checked operation");
    a_end_clears: assert property (guarded_op_end || hold_abort |=> !write_latch)
        else $error("latch kept after operation end or hold abort");
    a_freeze_sticks: assert property (frozen_reg |-> !lockdown_allow)
        else $error("lockdown allow set after freeze");
    a_reset_allowed: assert property (soft_reset_req |-> reset_cmd_allow)
        else $error("reset request while reset is not allowed");
    a_guard_bit: assert property ($stable(write_guard_n_pin) [*8] |->
        flash_status_low[4] == write_guard_n_pin) else $error("guard bit wrong");
    a_busy_bits: assert property ($stable(busy_in) [*3] |-> flash_status_low[0] == busy_in
        && flash_status_high[0] == busy_in) else $error("busy bits wrong");
    a_soft_code: assert property ($stable(soft_code) [*3] |->
        flash_status_low[3:2] == soft_code) else $error("protection summary wrong");
    a_high_fields: assert property ($stable({reset_cmd_allow, lockdown_allow}) [*2] |->
        flash_status_high[7:3] == {3'h0, reset_cmd_allow, lockdown_allow})
        else $error("status byte two fields wrong");
    c_global: cover property (global_op_req);
    c_reset: cover property (soft_reset_req);
    c_freeze: cover property (freeze_done);
    c_fail: cover property (op_checked && op_failed);
endmodule
bind serial_flash_status_register flash_status_checker chk_i (
    .core_clk, .rst, .write_guard_n_pin, .busy_in, .all_sectors_protected,
    .some_sectors_protected, .op_checked, .op_failed, .guarded_op_end, .hold_abort,
    .freeze_done, .flash_status_low, .flash_status_high, .write_latch, .reset_cmd_allow,
    .lockdown_allow, .program_erase_fail, .global_op_req, .soft_reset_req
);
`default_nettype wire

// >>> dv/spi_host_model.sv
// Serial host model: chip select, serial clock and data in mode 0.
// Assumes the device samples data on rising serial clock edges.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // Serial pins.
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Sends n bits of x from bit 23 down and returns the bits read back.
    task automatic xfer(input logic [23:0] x, input int n, output logic [23:0] r);
        r = 24'h0;
        #2 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = x[23 - i];
            #62 sck = 1'b1;
            r = {r[22:0], so};
            #63 sck = 1'b0;
        end
        #62 cs_n = 1'b1;
        si = ~si;
        #200;
    endtask
endmodule
`default_nettype wire

// >>> dv/test_serial_flash_status_register.sv
// Testbench of the serial flash status block with a serial host model.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module test_serial_flash_status_register;
    logic core_clk, rst, guard_n, busy, psus, esus, allp, somep;
    logic e_wl, e_lk, e_ra, e_la, e_fl;
    logic [4:0] ev;
    logic [23:0] rd;
    logic [7:0] d;
    wire cs_n, sck, si, so, so_oe, wl, lk, ra, la, fl, gq, gp, srq;
    wire [7:0] st_lo, st_hi;
    wire [3:0] gc;
    int mismatches, n_checks, n_req, n_srq, n_oe;
    spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so));
    serial_flash_status_register dut (
        .core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
        .so_pin(so), .so_oe(so_oe), .write_guard_n_pin(guard_n), .busy_in(busy),
        .program_suspended(psus), .erase_suspended(esus), .all_sectors_protected(allp),
        .some_sectors_protected(somep), .op_checked(ev[0]), .op_failed(ev[1]),
        .guarded_op_end(ev[2]), .hold_abort(ev[3]), .freeze_done(ev[4]),
        .flash_status_low(st_lo), .flash_status_high(st_hi), .write_latch(wl),
        .protect_regs_lock(lk), .reset_cmd_allow(ra), .lockdown_allow(la),
        .program_erase_fail(fl), .global_op_req(gq), .global_op_code(gc),
        .global_prior_lock(gp), .soft_reset_req(srq)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        n_req <= n_req + int'(gq === 1'b1);
        n_srq <= n_srq + int'(srq === 1'b1);
        n_oe <= n_oe + int'(so_oe === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk1(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] exp_lo();
        return {e_lk, 1'b0, e_fl, guard_n, allp, allp | somep, e_wl, busy};
    endfunction
    function automatic logic [7:0] exp_hi();
        return {3'h0, e_ra, e_la, psus, esus, busy};
    endfunction
    task automatic fr(logic [23:0] x, int n);
        host.xfer(x, n, rd);
        @(negedge core_clk);
    endtask
    task automatic wren();
        fr(24'h060000, 8);
        e_wl = 1'b1;
    endtask
    task automatic pulse(logic [4:0] v);
        ev = v;
        @(negedge core_clk);
        ev = 5'h00;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic st_chk();
        chk1("latch", e_wl, wl);
        chk1("lock", e_lk, lk);
        chk1("reset_allow", e_ra, ra);
        chk1("lockdown_allow", e_la, la);
        chk1("fail", e_fl, fl);
    endtask
    task automatic levels(logic [1:0] sp);
        int q;
        q = n_oe;
        {busy, psus, esus} = 3'($urandom);
        {allp, somep} = sp;
        fr(24'h050000, 24);
        chk8("status_low", exp_lo(), rd[15:8]);
        chk8("status_high", exp_hi(), rd[7:0]);
        chk8("status_low_port", exp_lo(), st_lo);
        chk8("status_high_port", exp_hi(), st_hi);
        chk1("so_oe_used", 1'b1, n_oe > q);
        chk1("so_oe_idle", 1'b0, so_oe);
    endtask
    task automatic wr1(logic [7:0] x, int n);
        int q;
        logic ok;
        q = n_req;
        wren();
        chk1("latch_set", 1'b1, wl);
        ok = (n % 8 == 0) && !(guard_n == 1'b0 && x[7] == 1'b0);
        fr({8'h01, x, 8'($urandom)}, n);
        if (ok) begin
            chk1("prior_lock", e_lk, gp);
            chk8("code", {4'h0, x[5:2]}, {4'h0, gc});
            e_lk = x[7];
        end
        e_wl = 1'b0;
        chk8("requests", 8'(q + int'(ok)), 8'(n_req));
        st_chk();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge core_clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h91B24E7F));
        {rst, guard_n, busy, psus, esus, allp, somep} = 7'h60;
        {e_wl, e_lk, e_ra, e_la, e_fl} = 5'h00;
        ev = 5'h00;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        st_chk();
        for (int i = 0; i < 4; i++) begin
            levels(2'(i));
        end
        fr(24'hF0D000, 16);
        chk8("soft_resets", 8'h00, 8'(n_srq));
        fr(24'h018000, 16);
        st_chk();
        for (int i = 0; i < 10; i++) begin
            guard_n = 1'($urandom);
            wr1(8'($urandom), (i % 3 == 2) ? 24 : 16);
        end
        guard_n = 1'b0;
        wr1(8'h80, 16);
        wr1(8'h3C, 16);
        levels(2'h1);
        guard_n = 1'b1;
        wr1(8'h00, 12);
        wr1(8'h00, 16);
        wren();
        fr(24'h010000, 4);
        fr(24'hAB0000, 8);
        st_chk();
        fr(24'h040000, 8);
        e_wl = 1'b0;
        st_chk();
        for (int i = 0; i < 2; i++) begin
            wren();
            pulse(5'h04 << i);
            e_wl = 1'b0;
            st_chk();
        end
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            pulse({3'h0, d[0], 1'b1});
            e_fl = d[0];
            st_chk();
        end
        pulse(5'h01);
        e_fl = 1'b0;
        pulse(5'h06);
        st_chk();
        wren();
        fr(24'h311800, 16);
        {e_ra, e_la, e_wl} = 3'h6;
        st_chk();
        levels(2'h3);
        pulse(5'h04);
        wren();
        fr(24'hF0D000, 16);
        e_wl = 1'b0;
        chk8("soft_resets", 8'h01, 8'(n_srq));
        st_chk();
        pulse(5'h10);
        e_la = 1'b0;
        st_chk();
        wren();
        fr(24'h310800, 16);
        {e_ra, e_wl} = 2'h0;
        st_chk();
        end_of_test();
    end
endmodule
`default_nettype wire
